// ---- pkg/sfe_consts.svh ----
// Constants of the serial flash erase sequencer: opcodes, framing, geometry and timing
`ifndef SFE_CONSTS_SVH
`define SFE_CONSTS_SVH

// Command opcodes
`define SFE_OP_WRITE_ENABLE       8'h06
`define SFE_OP_SECTOR_ERASE       8'h20
`define SFE_OP_HALF_BLOCK_ERASE   8'h52
`define SFE_OP_BLOCK_ERASE        8'hd8
`define SFE_OP_CHIP_ERASE_A       8'h60
`define SFE_OP_CHIP_ERASE_B       8'hc7

// Link clocks per byte in each command framing, and the limit of the frame clock count
`define SFE_SINGLE_BYTE_CLKS      6'h08
`define SFE_QUAD_BYTE_CLKS        6'h02
`define SFE_FRAME_CNT_MAX         6'h3f

// Array geometry: 512 Mbit, 26 address bits
`define SFE_ADDR_BITS             26
`define SFE_SECTOR_LSB            12
`define SFE_HALF_BLOCK_LSB        15
`define SFE_BLOCK_LSB             16
`define SFE_REGION_LSB            22
`define SFE_BLOCK_COUNT           11'h400
`define SFE_BP_ALL_LEVEL          4'hb

// Timing: system clock rate and erase times in microseconds
`define SFE_CLK_MHZ               125
`define SFE_SECTOR_ERASE_TIME_US  30000
`define SFE_HALF_ERASE_TIME_US    150000
`define SFE_BLOCK_ERASE_TIME_US   300000
`define SFE_ARRAY_ERASE_TIME_US   1000000

`endif

// ---- pkg/sfe_pkg.sv ----
// Types shared by the serial flash erase sequencer
package sfe_pkg;

    typedef enum logic [1:0] {
        SFE_KIND_SECTOR,
        SFE_KIND_HALF,
        SFE_KIND_BLOCK,
        SFE_KIND_CHIP
    } sfe_kind_t;

    typedef enum {
        SFE_IDLE,
        SFE_BUSY
    } sfe_state_t;

endpackage

// ---- logic/sfe_erase.sv ----
// Serial flash erase sequencer: link-side frame capture and self-timed erase control
//
// Functional notes
// R1: Sector erase sets every byte of the addressed 4 KB sector to ones.
// R2: Host issues write-enable first so the write enable latch is set.
// R3: Sector erase accepts any address in sector; sector chosen by A12 upward.
// R4: Sector/block erase framing must end exactly after last address bit, else rejected.
// R5: Host frames erase as select low, opcode, 3 or 4 address bytes, select high.
// R6: Addresses are 3 bytes unless four-byte mode or extended address bit applies; code takes 4 bytes only in four-byte mode, extended bit just gives A24.
// R7: Opcode taken as 8 single-wire or 2 quad-wire clocks; upper lines ignored single.
// R8: Erase starts at select rise; progress bit set during it, clears with latch.
// R9: Progress bit stays readable while an erase runs.
// R10: Sector/block erase refused on blocks protected by the active protect scheme.
// R11: Half-block erase clears addressed 32 KB block, chosen by A15 upward.
// R12: Block erase clears addressed 64 KB block; any address inside is valid.
// R13: Chip erase framed as select low, opcode, select high; clears whole array.
// R14: Chip erase select must rise exactly at opcode end, else rejected.
// R15: With protect select 0, chip erase runs only if all protect bits zero.
// R16: With protect select 1, chip erase skips protected blocks, including top/bottom ones.
// R17: Rejected commands leave array unchanged and never set the progress bit.
`timescale 1ns/100ps
`include "sfe_consts.svh"

module sfe_erase
    import sfe_pkg::*;
#(
    parameter int unsigned SECTOR_ERASE_CYCLES = `SFE_SECTOR_ERASE_TIME_US * `SFE_CLK_MHZ,
    parameter int unsigned HALF_ERASE_CYCLES   = `SFE_HALF_ERASE_TIME_US * `SFE_CLK_MHZ,
    parameter int unsigned BLOCK_ERASE_CYCLES  = `SFE_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
    parameter int unsigned ARRAY_ERASE_CYCLES  = `SFE_ARRAY_ERASE_TIME_US * `SFE_CLK_MHZ
) (
    // System clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_rst_n,
    // Serial link
    input  wire logic                      i_sclk,
    input  wire logic                      i_cs_n,
    input  wire logic [3:0]                i_sio,
    // Mode and protection levels
    input  wire logic                      i_quad_command_mode,
    input  wire logic                      i_four_byte_mode,
    input  wire logic                      i_extended_address_bit,
    input  wire logic                      i_protect_select,
    input  wire logic [3:0]                i_block_protect_bits,
    input  wire logic [15:0]               i_persistent_sector_lock,
    input  wire logic [15:0]               i_dynamic_sector_lock,
    // Status
    output logic                           o_write_in_progress,
    output logic                           o_write_enable_latch,
    output logic                           o_cmd_rejected,
    // Erase engine request
    output logic                           o_erase_go,
    output logic [1:0]                     o_erase_kind,
    output logic [`SFE_ADDR_BITS-1:0]      o_erase_base,
    output logic [15:0]                    o_erase_skip_mask
);

    // ---------------- Link domain ----------------
    logic        armed_reg;
    logic [5:0]  cnt_reg;
    logic [39:0] single_reg;
    logic [39:0] quad_reg;
    logic        frame_tgl_reg;

    // Select high arms the next frame; the link clock may stop outside frames.
    // Reset arms it too, so the first frame after reset is never missed.
    always_ff @(posedge i_sclk or posedge i_cs_n or negedge i_rst_n) begin
        if (!i_rst_n) begin
            armed_reg <= 1'b1;
        end else if (i_cs_n) begin
            armed_reg <= 1'b1;
        end else begin
            armed_reg <= 1'b0;
        end
    end

    // Both framings are captured; the system side picks one, so the mode never crosses
    always_ff @(posedge i_sclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg       <= 6'h00;
            single_reg    <= 40'h0;
            quad_reg      <= 40'h0;
            frame_tgl_reg <= 1'b0;
        end else if (!i_cs_n) begin
            if (armed_reg) begin
                cnt_reg       <= 6'h01;
                single_reg    <= {39'h0, i_sio[0]}; // R7
                quad_reg      <= {36'h0, i_sio};    // R7
                frame_tgl_reg <= ~frame_tgl_reg;
            end else begin
                if (cnt_reg != `SFE_FRAME_CNT_MAX) begin
                    cnt_reg <= cnt_reg + 6'h01;
                end
                single_reg <= {single_reg[38:0], i_sio[0]};
                quad_reg   <= {quad_reg[35:0], i_sio};
            end
        end
    end

    // ---------------- System domain ----------------
    logic [2:0]  cs_sync_reg;
    logic [1:0]  tgl_sync_reg;
    logic        tgl_seen_reg;
    logic        quad_s1_reg, quad_reg_s;
    logic        four_s1_reg, four_reg_s;
    logic        ext_s1_reg, ext_reg_s;
    logic        psel_s1_reg, psel_reg_s;
    logic [3:0]  bp_s1_reg, bp_reg_s;
    logic [31:0] lock_s1_reg, lock_reg_s;
    logic [15:0] lock_map;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cs_sync_reg  <= 3'h7;
            tgl_sync_reg <= 2'h0;
            quad_s1_reg  <= 1'b0;
            quad_reg_s   <= 1'b0;
            four_s1_reg  <= 1'b0;
            four_reg_s   <= 1'b0;
            ext_s1_reg   <= 1'b0;
            ext_reg_s    <= 1'b0;
            psel_s1_reg  <= 1'b0;
            psel_reg_s   <= 1'b0;
            bp_s1_reg    <= 4'h0;
            bp_reg_s     <= 4'h0;
            lock_s1_reg  <= 32'h0;
            lock_reg_s   <= 32'h0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[1:0], i_cs_n};
            tgl_sync_reg <= {tgl_sync_reg[0], frame_tgl_reg};
            quad_s1_reg  <= i_quad_command_mode;
            quad_reg_s   <= quad_s1_reg;
            four_s1_reg  <= i_four_byte_mode;
            four_reg_s   <= four_s1_reg;
            ext_s1_reg   <= i_extended_address_bit;
            ext_reg_s    <= ext_s1_reg;
            psel_s1_reg  <= i_protect_select;
            psel_reg_s   <= psel_s1_reg;
            bp_s1_reg    <= i_block_protect_bits;
            bp_reg_s     <= bp_s1_reg;
            lock_s1_reg  <= {i_persistent_sector_lock, i_dynamic_sector_lock};
            lock_reg_s   <= lock_s1_reg;
        end
    end

    // Both lock maps are synchronised before they are merged, so no gate sees a raw pin
    assign lock_map = lock_reg_s[31:16] | lock_reg_s[15:0];

    // A frame is judged once, at the synchronised select rise of a frame that saw clocks.
    // Link registers are stable then because the link clock is idle while select is high.
    logic eval;
    assign eval = cs_sync_reg[1] & ~cs_sync_reg[2] & (tgl_sync_reg[1] != tgl_seen_reg);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tgl_seen_reg <= 1'b0;
        end else if (eval) begin
            tgl_seen_reg <= tgl_sync_reg[1];
        end
    end

    // Frame decode
    logic [39:0]               frame;
    logic [5:0]                byte_clks;
    logic [5:0]                addr_frame_clks;
    logic [7:0]                addr_op;
    logic [`SFE_ADDR_BITS-1:0] addr;
    logic                      addr_frame_ok;
    logic                      op_frame_ok;
    logic                      is_sector, is_half, is_block, is_chip, is_write_enable_cmd;
    logic                      is_erase;
    logic [9:0]                blk_idx;
    logic [10:0]               bp_count;
    logic                      bp_hit;
    logic                      prot_hit;
    logic                      refuse;

    always_comb begin
        frame           = quad_reg_s ? quad_reg : single_reg;
        byte_clks       = quad_reg_s ? `SFE_QUAD_BYTE_CLKS : `SFE_SINGLE_BYTE_CLKS;
        addr_frame_clks = four_reg_s ? byte_clks * 6'h05 : byte_clks * 6'h04; // R6
        addr_frame_ok   = (cnt_reg == addr_frame_clks); // R4
        op_frame_ok     = (cnt_reg == byte_clks);       // R14
        addr_op         = four_reg_s ? frame[39:32] : frame[31:24];
        // Default three-byte addresses take A24 from the extended address bit; A25 is held at zero
        addr            = four_reg_s ? frame[`SFE_ADDR_BITS-1:0]
                                     : {1'b0, ext_reg_s, frame[23:0]}; // R6
        is_sector = addr_frame_ok && (addr_op == `SFE_OP_SECTOR_ERASE);     // R1
        is_half   = addr_frame_ok && (addr_op == `SFE_OP_HALF_BLOCK_ERASE); // R11
        is_block  = addr_frame_ok && (addr_op == `SFE_OP_BLOCK_ERASE);      // R12
        is_chip   = op_frame_ok && ((frame[7:0] == `SFE_OP_CHIP_ERASE_A) ||
                                    (frame[7:0] == `SFE_OP_CHIP_ERASE_B)); // R13
        is_write_enable_cmd   = op_frame_ok && (frame[7:0] == `SFE_OP_WRITE_ENABLE);
        is_erase  = is_sector | is_half | is_block | is_chip;
        // Block protect guards the top 2^(level-1) blocks; level 11 and up guards all
        blk_idx   = addr[`SFE_ADDR_BITS-1:`SFE_BLOCK_LSB];
        bp_count  = (bp_reg_s == 4'h0) ? 11'h000 : (11'h001 << (bp_reg_s - 4'h1));
        bp_hit    = (bp_reg_s >= `SFE_BP_ALL_LEVEL) ||
                    (({1'b0, blk_idx} + bp_count) > (`SFE_BLOCK_COUNT - 11'h001));
        prot_hit  = psel_reg_s ? lock_map[addr[`SFE_ADDR_BITS-1:`SFE_REGION_LSB]]
                               : bp_hit; // R10
        if (is_chip) begin
            refuse = !psel_reg_s && (bp_reg_s != 4'h0); // R15
        end else begin
            refuse = prot_hit; // R10
        end
    end

    // Erase control
    sfe_state_t state_reg;
    logic [31:0] timer_reg;
    logic        accept;

    assign accept = eval && (state_reg == SFE_IDLE) && is_erase &&
                    o_write_enable_latch && !refuse; // R2 R17

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= SFE_IDLE;
            timer_reg <= 32'h0;
        end else begin
            case (state_reg)
                SFE_IDLE: begin
                    if (accept) begin
                        state_reg <= SFE_BUSY; // R8
                        if (is_chip) begin
                            timer_reg <= 32'(ARRAY_ERASE_CYCLES);
                        end else if (is_block) begin
                            timer_reg <= 32'(BLOCK_ERASE_CYCLES);
                        end else if (is_half) begin
                            timer_reg <= 32'(HALF_ERASE_CYCLES);
                        end else begin
                            timer_reg <= 32'(SECTOR_ERASE_CYCLES);
                        end
                    end
                end
                SFE_BUSY: begin
                    if (timer_reg <= 32'h1) begin
                        state_reg <= SFE_IDLE;
                        timer_reg <= 32'h0;
                    end else begin
                        timer_reg <= timer_reg - 32'h1;
                    end
                end
                default: begin
                    state_reg <= SFE_IDLE;
                end
            endcase
        end
    end

    // Progress and latch; write-enable frames during an erase are ignored, so no set/clear race
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_write_in_progress  <= 1'b0;
            o_write_enable_latch <= 1'b0;
        end else if (accept) begin
            o_write_in_progress <= 1'b1; // R8 R9
        end else if (state_reg == SFE_BUSY && timer_reg <= 32'h1) begin
            o_write_in_progress  <= 1'b0; // R8
            o_write_enable_latch <= 1'b0; // R8
        end else if (eval && state_reg == SFE_IDLE && is_write_enable_cmd) begin
            o_write_enable_latch <= 1'b1; // R2
        end
    end

    // Erase request to the array engine, aligned to the erase unit
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_erase_go        <= 1'b0;
            o_erase_kind      <= 2'h0;
            o_erase_base      <= '0;
            o_erase_skip_mask <= 16'h0;
            o_cmd_rejected    <= 1'b0;
        end else begin
            o_erase_go     <= accept;
            o_cmd_rejected <= eval && (state_reg == SFE_IDLE) && is_erase && !accept; // R17
            if (accept) begin
                o_erase_skip_mask <= 16'h0;
                o_erase_base      <= '0;
                if (is_chip) begin
                    o_erase_kind      <= SFE_KIND_CHIP;
                    o_erase_skip_mask <= psel_reg_s ? lock_map : 16'h0; // R16
                end else if (is_block) begin
                    o_erase_kind <= SFE_KIND_BLOCK;
                    o_erase_base <= {addr[`SFE_ADDR_BITS-1:`SFE_BLOCK_LSB], 16'h0}; // R12
                end else if (is_half) begin
                    o_erase_kind <= SFE_KIND_HALF;
                    o_erase_base <= {addr[`SFE_ADDR_BITS-1:`SFE_HALF_BLOCK_LSB], 15'h0}; // R11
                end else begin
                    o_erase_kind <= SFE_KIND_SECTOR;
                    o_erase_base <= {addr[`SFE_ADDR_BITS-1:`SFE_SECTOR_LSB], 12'h0}; // R3
                end
            end
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    AST_GO_SETS_WIP: assert property (o_erase_go |-> o_write_in_progress) // R8
        else $error("erase started without progress bit");
    AST_WEL_CLEARS_WITH_WIP: assert property ($fell(o_write_in_progress) |-> !o_write_enable_latch) // R8
        else $error("write enable latch not cleared at erase end");
    AST_NEEDS_WEL: assert property ($rose(o_write_in_progress) |-> $past(o_write_enable_latch)) // R2
        else $error("erase started without write enable latch");
    AST_SECTOR_ALIGN: assert property (o_erase_go && o_erase_kind == SFE_KIND_SECTOR
        |-> o_erase_base[11:0] == 12'h0) // R3
        else $error("sector base not aligned");
    AST_HALF_ALIGN: assert property (o_erase_go && o_erase_kind == SFE_KIND_HALF
        |-> o_erase_base[14:0] == 15'h0) // R11
        else $error("half block base not aligned");
    AST_BLOCK_ALIGN: assert property (o_erase_go && o_erase_kind == SFE_KIND_BLOCK
        |-> o_erase_base[15:0] == 16'h0) // R12
        else $error("block base not aligned");
    AST_BAD_FRAME: assert property (eval && state_reg == SFE_IDLE && !is_erase
        |=> (!o_erase_go && !o_write_in_progress) [*2]) // R4
        else $error("misframed command acted on");
    AST_CHIP_BP: assert property (eval && is_chip && !psel_reg_s && bp_reg_s != 4'h0
        |=> !o_erase_go ##1 !o_erase_go) // R15
        else $error("chip erase ran with block protect set");
    AST_PROT_REFUSE: assert property (eval && refuse |-> ##1 !o_erase_go ##0 o_cmd_rejected == is_erase
        || state_reg == SFE_BUSY) // R10
        else $error("protected erase not refused");
    AST_WIP_HOLDS: assert property (state_reg == SFE_BUSY && timer_reg > 32'h1 |=> o_write_in_progress) // R9
        else $error("progress bit dropped during erase");

    COV_SECTOR: cover property (o_erase_go && o_erase_kind == SFE_KIND_SECTOR);
    COV_CHIP_SKIP: cover property (o_erase_go && o_erase_kind == SFE_KIND_CHIP && o_erase_skip_mask != 16'h0);
    COV_REJECT: cover property (o_cmd_rejected);
    COV_DONE: cover property ($fell(o_write_in_progress));

endmodule

// ---- verif/sfe_host_model.sv ----
// Host-side model that frames erase commands on the serial link
`timescale 1ns/100ps

module sfe_host_model (
    // Serial link
    output logic       o_sclk,
    output logic       o_cs_n,
    output logic [3:0] o_sio
);
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_sio  = 4'h5;
    end

    // Clock stands still between frames; released lines show inverted data
    task automatic send_frame(input logic [7:0] op, input int nb, input logic [31:0] a,
                              input logic q, input int extra);
        logic [39:0] bits;
        int          n;
        bits = {op, 32'h0};
        if (nb == 3)
            bits[31:8] = a[23:0];
        if (nb == 4)
            bits[31:0] = a;
        n = (q ? 2 : 8) * (1 + nb) + extra;
        #3 o_cs_n = 1'h0;
        for (int k = 0; k < n; k++) begin
            // Junk on the upper lines in single-wire framing must not matter
            if (q)
                o_sio = bits[39:36];
            else
                o_sio = {3'($urandom), bits[39]};
            bits = q ? bits << 4 : bits << 1;
            #16 o_sclk = 1'h1;
            #16 o_sclk = 1'h0;
        end
        #16 o_cs_n = 1'h1;
        o_sio = ~o_sio;
    endtask
endmodule

// ---- verif/serial_flash_erase_commands_bench.sv ----
// Self-checking bench for the serial flash erase sequencer
`timescale 1ns/100ps
`include "sfe_consts.svh"

module serial_flash_erase_commands_bench
    import sfe_pkg::*;
();
    logic        i_sys_clk;
    logic        i_rst_n;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  sio;
    logic        q_mode;
    logic        fb_mode;
    logic        ext;
    logic        ps;
    logic [3:0]  bp;
    logic [15:0] pl;
    logic [15:0] dl;
    logic        write_in_progress;
    logic        write_enable_latch;
    logic        rej;
    logic        go;
    logic [1:0]  kind;
    logic [25:0] base;
    logic [15:0] mask;
    logic [7:0]  ops [5] = '{`SFE_OP_SECTOR_ERASE, `SFE_OP_HALF_BLOCK_ERASE,
                            `SFE_OP_BLOCK_ERASE, `SFE_OP_CHIP_ERASE_A, `SFE_OP_CHIP_ERASE_B};
    logic [7:0]  op;
    logic [31:0] a;
    logic        r;
    int          miscompares;
    int          n_checks;

    initial begin
        i_sys_clk = 1'h0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    sfe_erase #(.SECTOR_ERASE_CYCLES(20), .HALF_ERASE_CYCLES(30),
                .BLOCK_ERASE_CYCLES(40), .ARRAY_ERASE_CYCLES(50)) sfe_erase_inst (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sio(sio), .i_quad_command_mode(q_mode), .i_four_byte_mode(fb_mode),
        .i_extended_address_bit(ext), .i_protect_select(ps), .i_block_protect_bits(bp),
        .i_persistent_sector_lock(pl), .i_dynamic_sector_lock(dl),
        .o_write_in_progress(write_in_progress), .o_write_enable_latch(write_enable_latch), .o_cmd_rejected(rej),
        .o_erase_go(go), .o_erase_kind(kind), .o_erase_base(base), .o_erase_skip_mask(mask));

    sfe_host_model sfe_host_model_inst (.o_sclk(sclk), .o_cs_n(cs_n), .o_sio(sio));

    task automatic check_bit(input string nm, input logic e, input logic s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic check_vec(input string nm, input logic [25:0] e, input logic [25:0] s);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    function automatic logic [1:0] kind_of(input logic [7:0] o);
        case (o)
            `SFE_OP_SECTOR_ERASE:     return 2'h0;
            `SFE_OP_HALF_BLOCK_ERASE: return 2'h1;
            `SFE_OP_BLOCK_ERASE:      return 2'h2;
            default:                  return 2'h3;
        endcase
    endfunction

    function automatic logic [25:0] full_addr(input logic [31:0] x);
        return fb_mode ? x[25:0] : {1'h0, ext, x[23:0]};
    endfunction

    function automatic logic locked(input logic [25:0] f);
        if (ps)
            return pl[f[25:22]] | dl[f[25:22]];
        if (bp == 4'h0)
            return 1'h0;
        if (bp >= `SFE_BP_ALL_LEVEL)
            return 1'h1;
        return int'(f[25:16]) >= 1024 - (1 << (bp - 1));
    endfunction

    // Straps settle well before the next frame ends
    task automatic straps(input logic q, input logic f, input logic e, input logic p,
                          input logic [3:0] b);
        @(posedge i_sys_clk) #1;
        q_mode = q;
        fb_mode = f;
        ext = e;
        ps = p;
        bp = b;
        pl = 16'($urandom);
        dl = 16'($urandom);
    endtask

    task automatic write_enable_cmd();
        sfe_host_model_inst.send_frame(`SFE_OP_WRITE_ENABLE, 0, 0, q_mode, 0);
        repeat (10) @(posedge i_sys_clk);
        #1 check_bit("latch_set", 1'h1, write_enable_latch);
    endtask

    task automatic erase(input logic [7:0] o, input logic [31:0] x, input int extra,
                         input logic ego, input logic erej);
        logic [1:0]  k;
        logic [25:0] f;
        int          nb, n, g, cnt, sh;
        logic        sg, sr;
        k = kind_of(o);
        f = full_addr(x);
        nb = (k == 2'h3) ? 0 : (fb_mode ? 4 : 3);
        n = 20 + 10 * int'(k);
        sh = (k == 2'h0) ? 12 : (k == 2'h1) ? 15 : 16;
        sg = 1'h0;
        sr = 1'h0;
        g = 0;
        sfe_host_model_inst.send_frame(o, nb, x, q_mode, extra);
        for (int c = 0; c < 12; c++) begin
            @(posedge i_sys_clk) #1;
            if (go === 1'h1) begin
                sg = 1'h1;
                g = c;
                check_vec("kind", 26'(k), 26'(kind));
                if (k != 2'h3)
                    check_vec("base", (f >> sh) << sh, base);
                check_vec("skip", (k == 2'h3 && ps) ? 26'(pl | dl) : 26'h0, 26'(mask));
                check_bit("wip_on", 1'h1, write_in_progress);
            end
            sr = sr | (rej === 1'h1);
        end
        check_bit("go", ego, sg);
        check_bit("rejected", erej, sr);
        if (!sg) begin
            check_bit("wip_idle", 1'h0, write_in_progress);
        end else begin
            cnt = 11 - g;
            while (write_in_progress === 1'h1 && cnt < n + 20) begin
                @(posedge i_sys_clk) #1;
                cnt++;
            end
            check_bit("erase_time", 1'h1, cnt >= n - 1 && cnt <= n + 1);
            check_bit("latch_clear", 1'h0, write_enable_latch);
            if (cnt >= n + 20)
                end_of_test();
        end
    endtask

    initial begin
        miscompares = 0;
        n_checks = 0;
        i_rst_n = 1'h1;
        q_mode = 1'h0;
        fb_mode = 1'h0;
        ext = 1'h0;
        ps = 1'h0;
        bp = 4'h0;
        pl = 16'h0;
        dl = 16'h0;
        void'($urandom(42882));
        // Assert reset after time zero so the link-side flops see a real falling edge
        #1 i_rst_n = 1'h0;
        repeat (5) @(posedge i_sys_clk);
        #1 i_rst_n = 1'h1;
        check_bit("wip_rst", 1'h0, write_in_progress);
        check_bit("latch_rst", 1'h0, write_enable_latch);
        repeat (4) @(posedge i_sys_clk);
        erase(`SFE_OP_SECTOR_ERASE, $urandom, 0, 1'h0, 1'h1);
        for (int i = 0; i < 5; i++) begin
            straps(1'($urandom), 1'($urandom), 1'($urandom), 1'h0, 4'h0);
            write_enable_cmd();
            erase(ops[i], $urandom, 0, 1'h1, 1'h0);
        end
        write_enable_cmd();
        erase(`SFE_OP_SECTOR_ERASE, $urandom, 1, 1'h0, 1'h0);
        erase(`SFE_OP_BLOCK_ERASE, $urandom, -1, 1'h0, 1'h0);
        erase(`SFE_OP_CHIP_ERASE_B, 0, 8, 1'h0, 1'h0);
        check_bit("latch_kept", 1'h1, write_enable_latch);
        // Boundary of the smallest protect level: only the top 64 KB block is locked
        straps(1'h0, 1'h1, 1'h0, 1'h0, 4'h1);
        erase(`SFE_OP_SECTOR_ERASE, 32'h03ff_0000 | 16'($urandom), 0, 1'h0, 1'h1);
        erase(`SFE_OP_CHIP_ERASE_A, 0, 0, 1'h0, 1'h1);
        erase(`SFE_OP_BLOCK_ERASE, 32'h03fe_0000 | 16'($urandom), 0, 1'h1, 1'h0);
        straps(1'h1, 1'h0, 1'h0, 1'h1, 4'hf);
        write_enable_cmd();
        erase(`SFE_OP_CHIP_ERASE_A, 0, 0, 1'h1, 1'h0);
        for (int i = 0; i < 14; i++) begin
            straps(1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 4'($urandom));
            write_enable_cmd();
            op = ops[$urandom % 5];
            a = $urandom;
            r = (kind_of(op) == 2'h3) ? (!ps && bp != 4'h0) : locked(full_addr(a));
            erase(op, a, 0, !r, r);
        end
        end_of_test();
    end
endmodule
